// [bcd_pkg.sv]
package bcd_pkg;
  // Special file addresses
  localparam logic [6:0] F_TIMER0_COUNT = 7'h01;
  localparam logic [6:0] F_STATUS = 7'h03;
  localparam logic [6:0] F_PORT = 7'h06;
  // Identification words sit above the 13-bit execution space
  localparam logic [13:0] ID_BASE = 14'h2000;
  localparam int unsigned ID_WORDS = 4;
  localparam int unsigned STK_DEPTH = 8;
  // Register port offsets
  localparam logic [3:0] R_CTRL = 4'h0;
  localparam logic [3:0] R_STATUS = 4'h1;
  localparam logic [3:0] R_W = 4'h2;
  localparam logic [3:0] R_PC = 4'h3;
  localparam logic [3:0] R_TIMER0_COUNT = 4'h4;
  localparam logic [3:0] R_ID_ADDR = 4'h5;
  localparam logic [3:0] R_ID_DATA = 4'h6;
  // Control bit positions and reset value
  localparam int unsigned CB_RUN = 0;
  localparam int unsigned CB_PROG = 1;
  localparam int unsigned CB_PSA = 2;
  localparam int unsigned CB_GIE = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // Status bit positions and reset value (expiry and sleep flags high)
  localparam int unsigned SB_C = 0;
  localparam int unsigned SB_DC = 1;
  localparam int unsigned SB_Z = 2;
  localparam int unsigned SB_PD = 3;
  localparam int unsigned SB_TO = 4;
  localparam logic [4:0] STATUS_RST = 5'h18;
  localparam logic [12:0] PC_RST = 13'h0;
  // Byte-oriented operation codes
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_CLEAR = 4'h1;
  localparam logic [3:0] OP_SUB_W_FILE = 4'h2;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_OR_W_FILE = 4'h4;
  localparam logic [3:0] OP_AND_W_FILE = 4'h5;
  localparam logic [3:0] OP_XOR_W_FILE = 4'h6;
  localparam logic [3:0] OP_ADD_W_FILE = 4'h7;
  localparam logic [3:0] OP_MOVE = 4'h8;
  localparam logic [3:0] OP_COMP = 4'h9;
  localparam logic [3:0] OP_INC = 4'ha;
  localparam logic [3:0] OP_DEC_SKIP_ZERO = 4'hb;
  localparam logic [3:0] OP_ROTATE_RIGHT_CARRY = 4'hc;
  localparam logic [3:0] OP_ROTATE_LEFT_CARRY = 4'hd;
  localparam logic [3:0] OP_SWAP = 4'he;
  localparam logic [3:0] OP_INC_SKIP_ZERO = 4'hf;
  // Literal operation codes
  localparam logic [3:0] OP_OR_LITERAL = 4'h8;
  localparam logic [3:0] OP_AND_LITERAL = 4'h9;
  localparam logic [2:0] OP_LITERAL_MINUS_W = 3'h6;
  localparam logic [2:0] OP_ADD_LITERAL = 3'h7;
  // Fixed control words, low byte
  localparam logic [7:0] LO_RETURN = 8'h08;
  localparam logic [7:0] LO_INTERRUPT_RETURN = 8'h09;
  localparam logic [7:0] LO_SLEEP = 8'h63;
  localparam logic [7:0] LO_WATCHDOG_CLEAR_OP = 8'h64;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_FLUSH = 3'b010,
    ST_SLEEP = 3'b100
  } bcd_state_t;
endpackage : bcd_pkg

// [bcd_addsub.sv]
`timescale 1ns/10ps
module bcd_addsub (
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic sub_i,
  output logic [7:0] y_o,
  output logic c_o,
  output logic dc_o
);
  logic [7:0] bb;
  logic [8:0] full;
  logic [4:0] half;
  // Subtract as a plus inverted b plus one, so carry out means no borrow
  assign bb = sub_i ? ~b_i : b_i;
  assign full = {1'b0, a_i} + {1'b0, bb} + 9'(sub_i);
  assign half = {1'b0, a_i[3:0]} + {1'b0, bb[3:0]} + 5'(sub_i);
  assign y_o = full[7:0];
  assign c_o = full[8];
  assign dc_o = half[4];
endmodule : bcd_addsub

// [bcd_core.sv]
`timescale 1ns/10ps
// How it works
// - File ops: top 00, op, dest, address; OR/AND/XOR touch only zero flag.
// - Rotates through carry, left 1101 right 1100, one cycle, carry only.
// - Decrement/increment and skip on zero result; no flags; two cycles when skipping.
// - Bit ops under 01: clear, set, test-skip-clear, test-skip-set with bit index.
// - Literal minus W and literal add update carry, half carry, zero.
// - OR and AND of literal into W update only zero flag.
// - Call, jump with 11-bit target, return-with-literal; each two cycles.
// - Standby and watchdog-clear words set the expiry flag; standby clears the sleep flag, watchdog-clear sets it.
// - Branch or true test costs a second, empty cycle.
// - Reads of the I/O port take pin levels, not the latch.
// - Writing the timer0 count clears the prescaler when assigned to timer0.
// - Four identification words unreachable by execution, accessible in program mode.
// - Interrupt return pops the stacked address and sets global enable.
module bcd_core
  import bcd_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  output logic [12:0] pmem_addr_o,
  input wire logic [13:0] pmem_data_i,
  input wire logic [7:0] pin_i,
  output logic [7:0] port_latch_o,
  output logic psc_clr_o,
  output logic wdt_clr_o,
  output logic sleep_o,
  input wire logic wake_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [15:0] reg_rdata_o
);
  import bcd_pkg::*;

  typedef struct packed {
    bcd_state_t st;
    logic skip;
    logic [12:0] pc;
    logic [7:0] w;
    logic [4:0] status;
    logic [3:0] ctrl;
    logic [7:0] timer0_count;
    logic [7:0] port;
    logic [2:0] sp;
    logic [STK_DEPTH-1:0][12:0] stk;
    logic [127:0][7:0] ram;
    logic [ID_WORDS-1:0][13:0] id;
    logic [1:0] id_idx;
    logic psc_clr;
    logic wdt_clr;
    logic [15:0] rdata;
  } bcd_core_st_t;

  bcd_core_st_t q;
  bcd_core_st_t d;
  logic [13:0] ins;
  logic [6:0] fa;
  logic dst;
  logic [2:0] bidx;
  logic [7:0] k8;
  logic [7:0] fval;
  logic [7:0] add_a;
  logic add_sub;
  logic [7:0] add_y;
  logic add_c;
  logic add_dc;
  logic ex;
  logic [7:0] res;
  logic wr_f;
  logic wr_w;
  logic upd_z;
  logic upd_c;
  logic upd_dc;
  logic new_c;
  logic new_dc;
  logic skip_now;

  assign ins = pmem_data_i;
  assign fa = ins[6:0];
  assign dst = ins[7];
  assign bidx = ins[9:7];
  assign k8 = ins[7:0];
  assign ex = (q.st == ST_RUN) && q.ctrl[CB_RUN];

  // Port reads always see the pins, so read-modify-write writes back pin levels
  always_comb
  begin
    case (fa)
      F_TIMER0_COUNT: fval = q.timer0_count;
      F_STATUS: fval = {3'h0, q.status};
      F_PORT: fval = pin_i;
      default: fval = q.ram[fa];
    endcase
  end

  assign add_a = (ins[13:12] == 2'b11) ? k8 : fval;
  assign add_sub = (ins[13:12] == 2'b11) ? (ins[11:9] == OP_LITERAL_MINUS_W) : (ins[11:8] == OP_SUB_W_FILE);

  bcd_addsub u_addsub (
    .a_i(add_a),
    .b_i(q.w),
    .sub_i(add_sub),
    .y_o(add_y),
    .c_o(add_c),
    .dc_o(add_dc)
  );

  always_comb
  begin
    d = q;
    res = fval;
    wr_f = 1'b0;
    wr_w = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    new_c = add_c;
    new_dc = add_dc;
    skip_now = 1'b0;
    d.psc_clr = 1'b0;
    d.wdt_clr = 1'b0;
    d.rdata = 16'h0;
    d.timer0_count = q.timer0_count + 8'h1;
    if (reg_we_i)
    begin
      case (reg_addr_i)
        R_CTRL: d.ctrl = reg_wdata_i[3:0];
        R_ID_ADDR: d.id_idx = reg_wdata_i[1:0];
        R_ID_DATA: if (q.ctrl[CB_PROG]) d.id[q.id_idx] = reg_wdata_i[13:0];
        default: d.rdata = 16'h0;
      endcase
    end
    if (reg_re_i)
    begin
      case (reg_addr_i)
        R_CTRL: d.rdata = {12'h0, q.ctrl};
        R_STATUS: d.rdata = {11'h0, q.status};
        R_W: d.rdata = {8'h0, q.w};
        R_PC: d.rdata = {3'h0, q.pc};
        R_TIMER0_COUNT: d.rdata = {8'h0, q.timer0_count};
        R_ID_ADDR: d.rdata = {14'h0, q.id_idx};
        R_ID_DATA: d.rdata = q.ctrl[CB_PROG] ? {2'h0, q.id[q.id_idx]} : 16'h0;
        default: d.rdata = 16'h0;
      endcase
    end
    case (q.st)
      ST_RUN:
      begin
        if (q.ctrl[CB_RUN])
        begin
          // A 13-bit counter can never reach the identification words
          d.pc = q.pc + 13'h1;
          case (ins[13:12])
            2'b00:
            begin
              if (ins[11:8] != OP_MISC)
              begin
                wr_f = dst;
                wr_w = !dst;
              end
              case (ins[11:8])
                OP_MISC:
                begin
                  if (dst)
                  begin
                    res = q.w;
                    wr_f = 1'b1;
                  end
                  else if (k8 == LO_RETURN || k8 == LO_INTERRUPT_RETURN)
                  begin
                    d.sp = q.sp - 3'h1;
                    d.pc = q.stk[q.sp - 3'h1];
                    d.st = ST_FLUSH;
                    if (k8[0])
                      d.ctrl[CB_GIE] = 1'b1;
                  end
                  else if (k8 == LO_SLEEP)
                  begin
                    d.status[SB_TO] = 1'b1;
                    d.status[SB_PD] = 1'b0;
                    d.wdt_clr = 1'b1;
                    d.st = ST_SLEEP;
                  end
                  else if (k8 == LO_WATCHDOG_CLEAR_OP)
                  begin
                    d.status[SB_TO] = 1'b1;
                    d.status[SB_PD] = 1'b1;
                    d.wdt_clr = 1'b1;
                  end
                end
                OP_CLEAR:
                begin
                  res = 8'h0;
                  upd_z = 1'b1;
                end
                OP_SUB_W_FILE, OP_ADD_W_FILE:
                begin
                  res = add_y;
                  upd_z = 1'b1;
                  upd_c = 1'b1;
                  upd_dc = 1'b1;
                end
                OP_DEC:
                begin
                  res = fval - 8'h1;
                  upd_z = 1'b1;
                end
                OP_OR_W_FILE:
                begin
                  res = fval | q.w;
                  upd_z = 1'b1;
                end
                OP_AND_W_FILE:
                begin
                  res = fval & q.w;
                  upd_z = 1'b1;
                end
                OP_XOR_W_FILE:
                begin
                  res = fval ^ q.w;
                  upd_z = 1'b1;
                end
                OP_MOVE, OP_COMP, OP_INC:
                begin
                  res = (ins[11:8] == OP_MOVE) ? fval : (ins[11:8] == OP_COMP) ? ~fval : fval + 8'h1;
                  upd_z = 1'b1;
                end
                OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO:
                begin
                  res = ins[10] ? fval + 8'h1 : fval - 8'h1;
                  skip_now = (res == 8'h0);
                end
                OP_ROTATE_RIGHT_CARRY:
                begin
                  res = {q.status[SB_C], fval[7:1]};
                  new_c = fval[0];
                  upd_c = 1'b1;
                end
                OP_ROTATE_LEFT_CARRY:
                begin
                  res = {fval[6:0], q.status[SB_C]};
                  new_c = fval[7];
                  upd_c = 1'b1;
                end
                OP_SWAP: res = {fval[3:0], fval[7:4]};
                default: res = fval;
              endcase
            end
            2'b01:
            begin
              if (!ins[11])
              begin
                res[bidx] = ins[10];
                wr_f = 1'b1;
              end
              else
                skip_now = (fval[bidx] == ins[10]);
            end
            2'b10:
            begin
              if (!ins[11])
              begin
                d.stk[q.sp] = q.pc + 13'h1;
                d.sp = q.sp + 3'h1;
              end
              d.pc = {q.pc[12:11], ins[10:0]};
              d.st = ST_FLUSH;
            end
            default:
            begin
              wr_w = 1'b1;
              res = k8;
              if (ins[11:10] == 2'b01)
              begin
                d.sp = q.sp - 3'h1;
                d.pc = q.stk[q.sp - 3'h1];
                d.st = ST_FLUSH;
              end
              else if (ins[11:8] == OP_OR_LITERAL || ins[11:8] == OP_AND_LITERAL)
              begin
                res = ins[8] ? (k8 & q.w) : (k8 | q.w);
                upd_z = 1'b1;
              end
              else if (ins[11:10] == 2'b11)
              begin
                res = add_y;
                upd_z = 1'b1;
                upd_c = 1'b1;
                upd_dc = 1'b1;
              end
              else if (ins[11:10] != 2'b00)
                wr_w = 1'b0;
            end
          endcase
          if (wr_w)
            d.w = res;
          if (wr_f)
          begin
            case (fa)
              F_TIMER0_COUNT:
              begin
                d.timer0_count = res;
                d.psc_clr = q.ctrl[CB_PSA];
              end
              F_STATUS: d.status[2:0] = res[2:0];
              F_PORT: d.port = res;
              default: d.ram[fa] = res;
            endcase
          end
          // Flags are applied after the file write so they win over a status target
          if (upd_z)
            d.status[SB_Z] = (res == 8'h0);
          if (upd_c)
            d.status[SB_C] = new_c;
          if (upd_dc)
            d.status[SB_DC] = new_dc;
          if (skip_now)
          begin
            d.st = ST_FLUSH;
            d.skip = 1'b1;
          end
        end
      end
      ST_FLUSH:
      begin
        // The fetched word is discarded; a skip also steps over it
        d.st = ST_RUN;
        d.skip = 1'b0;
        if (q.skip)
          d.pc = q.pc + 13'h1;
      end
      ST_SLEEP:
      begin
        if (wake_i)
          d.st = ST_RUN;
      end
      default: d.st = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      q <= '0;
      q.st <= ST_RUN;
      q.pc <= PC_RST;
      q.status <= STATUS_RST;
      q.ctrl <= CTRL_RST;
    end
    else
      q <= d;
  end

  assign pmem_addr_o = q.pc;
  assign port_latch_o = q.port;
  assign psc_clr_o = q.psc_clr;
  assign wdt_clr_o = q.wdt_clr;
  assign sleep_o = q.st[2];
  assign reg_rdata_o = q.rdata;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_flush_run;
    (q.st == ST_FLUSH) ##1 (q.st == ST_RUN);
  endsequence

  property p_or_zero;
    ex && ins[13:8] == {2'b00, OP_OR_W_FILE} && !dst |=>
      q.w == ($past(fval) | $past(q.w)) && q.status[SB_Z] == (q.w == 8'h0) && $stable(q.status[SB_C]);
  endproperty
  a_or_zero: assert property (p_or_zero) else $error("or_w_file result or flags wrong");

  property p_rotate_left;
    ex && ins[13:8] == {2'b00, OP_ROTATE_LEFT_CARRY} |=>
      q.status[SB_C] == $past(fval[7]) && $stable(q.status[SB_Z]);
  endproperty
  a_rotate_left: assert property (p_rotate_left) else $error("rotate_left_carry carry wrong");

  property p_dec_skip;
    ex && ins[13:8] == {2'b00, OP_DEC_SKIP_ZERO} && fval == 8'h1 ||
      ex && ins[13:8] == {2'b00, OP_INC_SKIP_ZERO} && fval == 8'hff |=> s_flush_run;
  endproperty
  a_dec_skip: assert property (p_dec_skip) else $error("skip on zero result missing");

  property p_bit_set;
    ex && ins[13:10] == 4'b0101 && fa > F_PORT |=> q.ram[$past(fa)][$past(bidx)];
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit_set_file bit not set");

  property p_add_literal;
    ex && ins[13:9] == {2'b11, OP_ADD_LITERAL} |=> q.w == 8'($past(k8) + $past(q.w));
  endproperty
  a_add_literal: assert property (p_add_literal) else $error("add_literal sum wrong");

  property p_and_literal;
    ex && ins[13:8] == {2'b11, OP_AND_LITERAL} |=>
      q.w == ($past(k8) & $past(q.w)) && q.status[SB_Z] == (q.w == 8'h0);
  endproperty
  a_and_literal: assert property (p_and_literal) else $error("and_literal result wrong");

  property p_jump;
    ex && ins[13:11] == 3'b101 |=> q.pc == {$past(q.pc[12:11]), $past(ins[10:0])} ##0 s_flush_run;
  endproperty
  a_jump: assert property (p_jump) else $error("jump target or timing wrong");

  property p_sleep;
    ex && ins == {6'h00, LO_SLEEP} |=> !q.status[SB_PD] && q.status[SB_TO] && wdt_clr_o && sleep_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("standby entry flags wrong");

  property p_pin_source;
    ex && ins[13:8] == {2'b00, OP_MOVE} && fa == F_PORT && dst |=> port_latch_o == $past(pin_i);
  endproperty
  a_pin_source: assert property (p_pin_source) else $error("port write back not from pins");

  property p_psc_clear;
    ex && wr_f && fa == F_TIMER0_COUNT |=> psc_clr_o == $past(q.ctrl[CB_PSA]);
  endproperty
  a_psc_clear: assert property (p_psc_clear) else $error("prescaler clear wrong");

  property p_id_hidden;
    reg_re_i && reg_addr_i == R_ID_DATA && !q.ctrl[CB_PROG] |=> reg_rdata_o == 16'h0;
  endproperty
  a_id_hidden: assert property (p_id_hidden) else $error("id word visible outside program mode");

  property p_irq_return;
    ex && ins == {6'h00, LO_INTERRUPT_RETURN} |=> q.ctrl[CB_GIE] && q.pc == $past(q.stk[q.sp - 3'h1]);
  endproperty
  a_irq_return: assert property (p_irq_return) else $error("interrupt_return wrong");

  property p_dest_w;
    ex && ins[13:8] == {2'b00, OP_ROTATE_LEFT_CARRY} && !dst && fa > F_PORT |=>
      q.w == {$past(fval[6:0]), $past(q.status[SB_C])} && q.ram[$past(fa)] == $past(fval);
  endproperty
  a_dest_w: assert property (p_dest_w) else $error("destination zero did not load W only");
endmodule : bcd_core

// [bcd_pmem.sv]
`timescale 1ns/10ps
module bcd_pmem (
  input wire logic [12:0] addr_i,
  output logic [13:0] data_o
);
  // Answers in the same cycle; places never loaded hold a no-operation word
  logic [13:0] mem_q [0:63];
  initial
  begin
    for (int i = 0; i < 64; i++) mem_q[i] = 14'h0000;
  end
  // Only the low address bits decode, so high addresses alias into the image
  assign data_o = mem_q[addr_i[5:0]];
endmodule : bcd_pmem

// [bcd_core_tb.sv]
`timescale 1ns/10ps
module bcd_core_tb;
  import bcd_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [12:0] pmem_addr;
  logic [13:0] pmem_data;
  logic [7:0] pin_i = 8'h00;
  logic [7:0] port_latch;
  logic psc_clr;
  logic wdt_clr;
  logic sleep_s;
  logic wake_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [15:0] reg_rdata;
  logic rd_seen_q = 1'b0;
  logic [15:0] exp_q[$];
  logic [13:0] prog[$];
  int err_total = 0;
  int comparisons = 0;
  int seed = 32'hfa4f;
  int psc_cnt = 0;
  int wdt_cnt = 0;

  initial
  begin
    forever #20 clk_i = ~clk_i;
  end

  bcd_pmem i_bcd_pmem (.addr_i(pmem_addr), .data_o(pmem_data));

  bcd_core i_bcd_core (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pmem_addr_o(pmem_addr),
    .pmem_data_i(pmem_data),
    .pin_i(pin_i),
    .port_latch_o(port_latch),
    .psc_clr_o(psc_clr),
    .wdt_clr_o(wdt_clr),
    .sleep_o(sleep_s),
    .wake_i(wake_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // Read data stands only in the cycle after the strobe, so it is sampled exactly there
  always @(posedge clk_i)
  begin
    rd_seen_q <= reg_re_i;
    if (psc_clr === 1'b1) psc_cnt++;
    if (wdt_clr === 1'b1) wdt_cnt++;
    if (rd_seen_q)
    begin
      if (exp_q.size() == 0)
        chk(reg_rdata, 16'hffff);
      else
        chk(reg_rdata, exp_q.pop_front());
    end
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    exp_q.push_back(e);
    @(posedge clk_i);
    reg_re_i <= 1'b0;
  endtask : rd

  task automatic rst();
    sys_rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
  endtask : rst

  // Loads the image while the core is stopped, starts it and waits for the final loop
  task automatic run(input logic [12:0] stop, input logic [3:0] ctrl);
    int n;
    for (int i = 0; i < 64; i++) i_bcd_pmem.mem_q[i] = (i < prog.size()) ? prog[i] : 14'h0000;
    wr(R_CTRL, {12'h000, ctrl});
    n = 0;
    while (pmem_addr !== stop && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 300)
    begin
      err_total++;
      wrap_up();
    end
    else
      repeat (4) @(posedge clk_i);
  endtask : run

  initial
  begin
    logic [7:0] a, b, c, d, w1, w4, wx, p;
    logic [8:0] s;
    logic cf, dc;
    int k0, k1;
    rst();
    rd(R_CTRL, 16'h0000);
    rd(R_STATUS, 16'h0018);
    rd(R_W, 16'h0000);
    rd(R_PC, 16'h0000);
    wr(R_STATUS, 16'h0007);
    rd(R_STATUS, 16'h0018);
    rd(4'hf, 16'h0000);
    wr(R_ID_ADDR, 16'h0002);
    wr(R_ID_DATA, 16'h2a5c);
    rd(R_ID_DATA, 16'h0000);
    wr(R_CTRL, 16'h0002);
    wr(R_ID_DATA, 16'h1b3d);
    rd(R_ID_DATA, 16'h1b3d);
    wr(R_ID_ADDR, 16'h0001);
    rd(R_ID_DATA, 16'h0000);
    // Logic, then add or subtract of literals with random operands
    for (int i = 0; i < 6; i++)
    begin
      a = 8'($random(seed));
      b = 8'($random(seed));
      c = 8'($random(seed));
      d = 8'($random(seed));
      w1 = a | b;
      w4 = (w1 & c) ^ w1;
      if (i[0])
      begin
        s = {1'b0, d - w4};
        cf = d >= w4;
        dc = d[3:0] >= w4[3:0];
      end
      else
      begin
        s = {1'b0, w4} + {1'b0, d};
        cf = s[8];
        dc = ({1'b0, w4[3:0]} + {1'b0, d[3:0]}) > 5'h0f;
      end
      wx = s[7:0];
      rst();
      prog = '{{6'h30, a}, {6'h38, b}, 14'h00a0, {6'h39, c}, 14'h0620, {i[0] ? 6'h3c : 6'h3e, d}, 14'h2806};
      run(13'h0006, 4'h1);
      rd(R_W, {8'h00, wx});
      rd(R_STATUS, {11'h000, 2'b11, wx == 8'h00, dc, cf});
      rd(R_PC, 16'h0006);
    end
    // Rotates, skips on zero and bit tests; a wrongly executed word corrupts W
    rst();
    prog = '{14'h3081, 14'h00a3, 14'h0d23, 14'h0c23, 14'h00a4, 14'h30ff, 14'h00a2, 14'h0fa2, 14'h3055, 14'h0ba2,
      14'h11a2, 14'h19a2, 14'h3055, 14'h15a2, 14'h1da2, 14'h3066, 14'h19a2, 14'h393c, 14'h0424, 14'h2813};
    run(13'h0013, 4'h1);
    rd(R_W, 16'h00fc);
    rd(R_STATUS, 16'h0019);
    // Port write-back from pins, timer0 write, watchdog clear and standby
    for (int k = 0; k < 2; k++)
    begin
      p = {1'b0, 7'($random(seed))};
      rst();
      pin_i <= p;
      k0 = psc_cnt;
      k1 = wdt_cnt;
      prog = '{14'h30ff, 14'h0086, 14'h0886, 14'h0081, 14'h0064, 14'h0063, 14'h2806};
      run(13'h0006, k[0] ? 4'h5 : 4'h1);
      chk({8'h00, port_latch}, {8'h00, p});
      chk(16'(psc_cnt - k0), 16'(k));
      chk(16'(wdt_cnt - k1), 16'h0002);
      chk({15'h0000, sleep_s}, 16'h0001);
      rd(R_STATUS, {11'h000, 2'b10, p == 8'h00, 2'b00});
      @(posedge clk_i);
      wake_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk({15'h0000, sleep_s}, 16'h0000);
      rd(R_PC, 16'h0006);
    end
    // Call, return with literal and interrupt return
    rst();
    prog = '{14'h2004, 14'h2006, 14'h2802, 14'h0000, 14'h345a, 14'h0000, 14'h0009};
    run(13'h0002, 4'h1);
    rd(R_W, 16'h005a);
    rd(R_PC, 16'h0002);
    rd(R_CTRL, 16'h0009);
    repeat (3) @(posedge clk_i);
    wrap_up();
  end
endmodule : bcd_core_tb
